// File: include/dsp_pkg.sv
// constants, types and code decoders for the drive setup policy decoder
package dsp_pkg;
   // ========================================
   // timing
   localparam int SYS_CLK_HZ = 50_000_000;
   localparam int PANEL_LOSS_MS = 1000;
   localparam int PANEL_LOSS_CYC = SYS_CLK_HZ / 1000 * PANEL_LOSS_MS;
   // ========================================
   // register port
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam logic [4:0] OFS_MOTOR = 5'h00;
   localparam logic [4:0] OFS_CARRIER = 5'h04;
   localparam logic [4:0] OFS_SOFTPWM = 5'h08;
   localparam logic [4:0] OFS_POLICY = 5'h0c;
   localparam logic [4:0] OFS_STATUS = 5'h10;
   localparam logic [4:0] OFS_IRQ_STS = 5'h14;
   localparam logic [4:0] OFS_IRQ_CLR = 5'h18;
   localparam logic [4:0] OFS_IRQ_EN = 5'h1c;
   // ========================================
   // reset values
   localparam logic [6:0] MOTOR_RST = 7'h00;
   localparam logic [3:0] CARRIER_RST = 4'h1;
   localparam logic SOFTPWM_RST = 1'b1;
   localparam logic [4:0] POLICY_RST = 5'h0e;
   // ========================================
   // code groups
   localparam logic [6:0] MOTOR_HI_GROUP = 7'h64;
   localparam logic [3:0] SOFT_PWM_MAX = 4'h5;
   localparam logic [4:0] POLICY_FB_GROUP = 5'h0e;
   localparam logic [4:0] POLICY_DET_LO = 5'h02;
   localparam logic [4:0] POLICY_DET_HI = 5'h10;
   localparam logic [4:0] POLICY_MAX = 5'h11;
   localparam logic [4:0] POLICY_LO_MAX = 5'h03;
   // value is arbitrary
   localparam logic [7:0] PANEL_LOSS_CODE = 8'h5e;
   localparam logic [7:0] ALARM_NONE = 8'h00;
   // ========================================
   // interrupt and status bits
   localparam int IRQ_W = 4;
   localparam int IRQ_LOSS = 0;
   localparam int IRQ_STOP = 1;
   localparam int IRQ_REJ = 2;
   localparam int IRQ_RST = 3;
   localparam int STS_W = 6;
   localparam int STS_ALARM = 0;
   localparam int STS_STOP = 1;
   localparam int STS_CT = 2;
   localparam int STS_TUNE = 3;
   localparam int STS_SPWM = 4;
   localparam int STS_DET = 5;
   typedef enum logic [1:0] {DSP_RUN, DSP_KEY_STOP, DSP_LOSS_TRIP} dsp_state_t;
   // ========================================
   // decoders
   function automatic logic [6:0] motor_base(input logic [6:0] c);
      motor_base = (c >= MOTOR_HI_GROUP) ? 7'(c - MOTOR_HI_GROUP) : c;
   endfunction
   function automatic logic motor_code_ok(input logic [6:0] c);
      logic [6:0] b;
      b = motor_base(c);
      motor_code_ok = b inside {7'h00, 7'h01, 7'h03, 7'h05, 7'h06, 7'h0d, 7'h0f, 7'h10, 7'h17};
   endfunction
   function automatic logic motor_base_ct(input logic [6:0] b);
      motor_base_ct = b inside {7'h01, 7'h0d, 7'h0f, 7'h10};
   endfunction
   function automatic logic motor_base_tune(input logic [6:0] b);
      motor_base_tune = b inside {7'h03, 7'h0d, 7'h17};
   endfunction
   function automatic logic motor_base_entry(input logic [6:0] b);
      motor_base_entry = b inside {7'h05, 7'h06, 7'h0f, 7'h10};
   endfunction
   function automatic logic motor_base_delta(input logic [6:0] b);
      motor_base_delta = b inside {7'h06, 7'h10};
   endfunction
   function automatic logic policy_ok(input logic [4:0] p);
      policy_ok = (p <= POLICY_LO_MAX) || (p >= POLICY_FB_GROUP && p <= POLICY_MAX);
   endfunction
endpackage

// File: rtl/dsp_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dsp_sync3 #(
   parameter int W = 1
) (
   // clock
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] agree;

   if (W < 1) begin : g_chk
      $error("dsp_sync3: width must be at least one");
   end

   assign agree = ~(s2_q ^ s3_q);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         sync_out <= (s3_q & agree) | (sync_out & ~agree);
      end
   end
endmodule
`default_nettype wire

// File: rtl/dsp_loss_timer.sv
// operator panel absence timer
`timescale 1ns/1ps
`default_nettype none
module dsp_loss_timer #(
   parameter int LIMIT = 50_000_000
) (
   // clock
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // control
   input wire logic detect_en,
   input wire logic panel_present,
   output logic loss_trip
);
   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LIM = CW'(LIMIT);
   localparam logic [CW-1:0] LIM_M1 = CW'(LIMIT - 1);
   logic armed_q;
   logic [CW-1:0] cnt_q;

   if (LIMIT < 2) begin : g_chk
      $error("dsp_loss_timer: limit must be at least two");
   end

   // armed only once a panel has been seen since reset
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         armed_q <= 1'b0;
      end else if (clk_en && panel_present) begin
         armed_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cnt_q <= '0;
         loss_trip <= 1'b0;
      end else if (clk_en) begin
         if (panel_present || !detect_en || !armed_q) begin
            cnt_q <= '0;
            loss_trip <= 1'b0;
         end else begin
            loss_trip <= (cnt_q == LIM_M1);
            if (cnt_q != LIM) begin
               cnt_q <= CW'(cnt_q + 1'b1);
            end
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   chk_loss_restart: assert property (clk_en && panel_present |=> cnt_q == '0)
      else $error("absence count not restarted by panel presence");
   chk_powerup_absent: assert property (!armed_q |-> !loss_trip)
      else $error("loss trip without a panel ever seen");
endmodule
`default_nettype wire

// File: rtl/dsp_drive_setup_policy.sv
// drive setup decoder: motor code, pwm carrier and panel policy
// ========================================
`timescale 1ns/1ps
`default_nettype none
module dsp_drive_setup_policy #(
   parameter int LOSS_CYC = dsp_pkg::PANEL_LOSS_CYC
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // register port
   input wire logic [dsp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [dsp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [dsp_pkg::DATA_W-1:0] reg_rdata,
   // pins from outside the clock domain
   input wire logic second_characteristic_select,
   input wire logic operator_panel_present,
   input wire logic panel_stop_key,
   input wire logic reset_input,
   // drive state on the same clock
   input wire logic protective_trip,
   input wire logic panel_operation_mode,
   input wire logic fieldbus_operation_mode,
   input wire logic rs485_link_mode,
   // thermal and motor setup
   output logic therm_const_torque,
   output logic autotune_select,
   output logic motor_const_entry,
   output logic delta_connection,
   // pwm
   output logic [3:0] carrier_code,
   output logic soft_pwm_active,
   // policy results
   output logic reset_accept,
   output logic panel_loss_alarm,
   output logic [7:0] alarm_code,
   output logic drive_shutoff,
   output logic decel_stop_req,
   output logic panel_stop_indication,
   output logic irq
);
   import dsp_pkg::*;

   // ========================================
   // synchronised pins
   logic char2_s;
   logic present_s;
   logic key_s;
   logic rst_s;
   logic key_prev_q;
   logic rst_prev_q;
   logic key_rise;
   logic rst_rise;

   dsp_sync3 #(
      .W(4)
   ) u_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .async_in({second_characteristic_select, operator_panel_present,
                 panel_stop_key, reset_input}),
      .sync_out({char2_s, present_s, key_s, rst_s})
   );

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         key_prev_q <= 1'b0;
         rst_prev_q <= 1'b0;
      end else if (clk_en) begin
         key_prev_q <= key_s;
         rst_prev_q <= rst_s;
      end
   end

   assign key_rise = key_s && !key_prev_q;
   assign rst_rise = rst_s && !rst_prev_q;

   // ========================================
   // configuration registers
   logic [6:0] motor_q;
   logic [3:0] carrier_q;
   logic softpwm_q;
   logic [4:0] policy_q;
   logic wr_motor;
   logic wr_carrier;
   logic wr_softpwm;
   logic wr_policy;
   logic motor_ok;
   logic carrier_ok;
   logic softpwm_ok;
   logic policy_wr_ok;
   logic wr_reject;

   assign wr_motor = reg_wr && (reg_addr == OFS_MOTOR);
   assign wr_carrier = reg_wr && (reg_addr == OFS_CARRIER);
   assign wr_softpwm = reg_wr && (reg_addr == OFS_SOFTPWM);
   assign wr_policy = reg_wr && (reg_addr == OFS_POLICY);
   assign motor_ok = (reg_wdata[31:7] == '0) && motor_code_ok(reg_wdata[6:0]);
   assign carrier_ok = (reg_wdata[31:4] == '0);
   assign softpwm_ok = (reg_wdata[31:1] == '0);
   assign policy_wr_ok = (reg_wdata[31:5] == '0) && policy_ok(reg_wdata[4:0]);
   assign wr_reject = (wr_motor && !motor_ok) || (wr_carrier && !carrier_ok)
                      || (wr_softpwm && !softpwm_ok) || (wr_policy && !policy_wr_ok);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         motor_q <= MOTOR_RST;
      end else if (clk_en && wr_motor && motor_ok) begin
         motor_q <= reg_wdata[6:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         carrier_q <= CARRIER_RST;
         softpwm_q <= SOFTPWM_RST;
      end else if (clk_en) begin
         if (wr_carrier && carrier_ok) begin
            carrier_q <= reg_wdata[3:0];
         end
         if (wr_softpwm && softpwm_ok) begin
            softpwm_q <= reg_wdata[0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         policy_q <= POLICY_RST;
      end else if (clk_en && wr_policy && policy_wr_ok) begin
         policy_q <= reg_wdata[4:0];
      end
   end

   // ========================================
   // motor and pwm decode
   logic [6:0] base;
   logic hi_group;

   assign base = motor_base(motor_q);
   assign hi_group = (motor_q >= MOTOR_HI_GROUP);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         therm_const_torque <= 1'b0;
         autotune_select <= 1'b0;
         motor_const_entry <= 1'b0;
         delta_connection <= 1'b0;
         carrier_code <= CARRIER_RST;
         soft_pwm_active <= 1'b0;
      end else if (clk_en) begin
         therm_const_torque <= motor_base_ct(base) || (hi_group && char2_s);
         autotune_select <= motor_base_tune(base);
         motor_const_entry <= motor_base_entry(base);
         delta_connection <= motor_base_delta(base);
         carrier_code <= carrier_q;
         soft_pwm_active <= softpwm_q && (carrier_q <= SOFT_PWM_MAX);
      end
   end

   // ========================================
   // panel policy
   logic fb_group;
   logic any_reset;
   logic det_en;
   logic loss_trip;
   logic stop_ok;
   logic rst_ok;
   dsp_state_t state_q;

   assign fb_group = (policy_q >= POLICY_FB_GROUP);
   assign any_reset = !policy_q[0];
   assign det_en = (fb_group ? (policy_q >= POLICY_DET_HI)
                             : (policy_q >= POLICY_DET_LO)) && !rs485_link_mode;
   assign stop_ok = key_rise && (panel_operation_mode
                                 || (fb_group && fieldbus_operation_mode));
   assign rst_ok = rst_rise && (any_reset || protective_trip
                                || state_q == DSP_LOSS_TRIP);

   dsp_loss_timer #(
      .LIMIT(LOSS_CYC)
   ) u_timer (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .detect_en(det_en),
      .panel_present(present_s),
      .loss_trip(loss_trip)
   );

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q <= DSP_RUN;
      end else if (clk_en) begin
         case (state_q)
            DSP_RUN: begin
               if (loss_trip) begin
                  state_q <= DSP_LOSS_TRIP;
               end else if (stop_ok) begin
                  state_q <= DSP_KEY_STOP;
               end
            end
            DSP_KEY_STOP: begin
               if (loss_trip) begin
                  state_q <= DSP_LOSS_TRIP;
               end else if (rst_ok) begin
                  state_q <= DSP_RUN;
               end
            end
            DSP_LOSS_TRIP: begin
               if (rst_ok) begin
                  state_q <= DSP_RUN;
               end
            end
            default: begin
               state_q <= DSP_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reset_accept <= 1'b0;
         panel_loss_alarm <= 1'b0;
         alarm_code <= ALARM_NONE;
         drive_shutoff <= 1'b0;
         decel_stop_req <= 1'b0;
         panel_stop_indication <= 1'b0;
      end else if (clk_en) begin
         reset_accept <= rst_ok;
         panel_loss_alarm <= (state_q == DSP_LOSS_TRIP);
         alarm_code <= (state_q == DSP_LOSS_TRIP) ? PANEL_LOSS_CODE : ALARM_NONE;
         drive_shutoff <= (state_q == DSP_LOSS_TRIP);
         decel_stop_req <= (state_q == DSP_KEY_STOP);
         panel_stop_indication <= (state_q == DSP_KEY_STOP);
      end
   end

   // ========================================
   // interrupts
   logic [IRQ_W-1:0] irq_sts_q;
   logic [IRQ_W-1:0] irq_en_q;
   logic [IRQ_W-1:0] ev_vec;
   logic [IRQ_W-1:0] clr_mask;

   always_comb begin
      ev_vec = '0;
      ev_vec[IRQ_LOSS] = loss_trip;
      ev_vec[IRQ_STOP] = stop_ok && (state_q == DSP_RUN) && !loss_trip;
      ev_vec[IRQ_REJ] = wr_reject;
      ev_vec[IRQ_RST] = rst_ok;
   end

   assign clr_mask = (reg_wr && reg_addr == OFS_IRQ_CLR) ? reg_wdata[IRQ_W-1:0] : '0;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irq_sts_q <= '0;
         irq_en_q <= '0;
         irq <= 1'b0;
      end else if (clk_en) begin
         irq_sts_q <= (irq_sts_q & ~clr_mask) | ev_vec;
         if (reg_wr && reg_addr == OFS_IRQ_EN) begin
            irq_en_q <= reg_wdata[IRQ_W-1:0];
         end
         irq <= |(irq_sts_q & irq_en_q);
      end
   end

   // ========================================
   // read port
   logic [STS_W-1:0] status;

   always_comb begin
      status = '0;
      status[STS_ALARM] = panel_loss_alarm;
      status[STS_STOP] = panel_stop_indication;
      status[STS_CT] = therm_const_torque;
      status[STS_TUNE] = autotune_select;
      status[STS_SPWM] = soft_pwm_active;
      status[STS_DET] = det_en;
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               OFS_MOTOR: reg_rdata <= {25'h0, motor_q};
               OFS_CARRIER: reg_rdata <= {28'h0, carrier_q};
               OFS_SOFTPWM: reg_rdata <= {31'h0, softpwm_q};
               OFS_POLICY: reg_rdata <= {27'h0, policy_q};
               OFS_STATUS: reg_rdata <= {26'h0, status};
               OFS_IRQ_STS: reg_rdata <= {28'h0, irq_sts_q};
               OFS_IRQ_EN: reg_rdata <= {28'h0, irq_en_q};
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

   // ========================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   chk_motor_keep: assert property (clk_en && wr_motor && !motor_ok
                                    |=> motor_q == $past(motor_q))
      else $error("rejected motor code changed the stored value");
   chk_codes_valid: assert property (motor_code_ok(motor_q) && policy_ok(policy_q))
      else $error("stored code outside the valid set");
   chk_therm_map: assert property (clk_en |=> therm_const_torque ==
      (motor_base_ct(motor_base($past(motor_q)))
       || ($past(motor_q) >= MOTOR_HI_GROUP && $past(char2_s))))
      else $error("thermal characteristic mismatch");
   chk_tune_map: assert property (clk_en
                                  |=> autotune_select == motor_base_tune(motor_base($past(motor_q))))
      else $error("auto tuning select mismatch");
   chk_soft_pwm: assert property (clk_en |=> soft_pwm_active ==
                                  ($past(softpwm_q) && $past(carrier_q) <= SOFT_PWM_MAX))
      else $error("soft pwm activity mismatch");
   chk_reset_gate: assert property (reset_accept && $past(clk_en) |->
      $past(!policy_q[0] || protective_trip || state_q == DSP_LOSS_TRIP))
      else $error("reset accepted against the policy");
   chk_loss_alarm: assert property (clk_en && loss_trip ##1 clk_en
      |=> panel_loss_alarm && drive_shutoff && alarm_code == PANEL_LOSS_CODE)
      else $error("panel loss did not raise the alarm");
   chk_det_gate: assert property (loss_trip && $past(clk_en) |-> $past(det_en))
      else $error("panel loss trip while detection disabled");
   chk_stop_panel: assert property (clk_en && key_rise && state_q == DSP_RUN
      && !fb_group && !panel_operation_mode |=> !decel_stop_req [*2])
      else $error("stop key acted outside panel mode");
   chk_stop_fb: assert property (clk_en && key_rise && state_q == DSP_RUN && !loss_trip
      && fb_group && fieldbus_operation_mode ##1 clk_en |=> decel_stop_req)
      else $error("stop key ignored in fieldbus mode");
   chk_stop_noalarm: assert property ($rose(panel_stop_indication) |-> !panel_loss_alarm)
      else $error("key stop raised the alarm");
   chk_irq_set: assert property (clk_en && loss_trip |=> irq_sts_q[IRQ_LOSS])
      else $error("loss event lost against a clear");

   cov_loss_trip: cover property (clk_en && loss_trip);
   cov_key_stop: cover property ($rose(decel_stop_req));
   cov_reset_acc: cover property (reset_accept && $past(panel_loss_alarm));
   cov_reject: cover property (clk_en && wr_reject);
endmodule
`default_nettype wire

// File: verification/dsp_panel_model.sv
// operator panel model: presence, stop key and reset pin
`timescale 1ns/1ps
`default_nettype none
module dsp_panel_model (
   // clock
   input wire logic sys_clk,
   // commands from the bench
   input wire logic attach,
   input wire logic key_cmd,
   input wire logic rst_cmd,
   // pins toward the block
   output logic present,
   output logic key,
   output logic rst_pin
);
   logic [3:0] key_q = 4'h0;
   logic [3:0] rst_q = 4'h0;
   // presses held long enough to pass the synchroniser
   always_ff @(posedge sys_clk) begin
      key_q <= key_cmd ? 4'h8 : (key_q != 4'h0 ? key_q - 4'h1 : 4'h0);
      rst_q <= rst_cmd ? 4'h8 : (rst_q != 4'h0 ? rst_q - 4'h1 : 4'h0);
   end
   assign present = attach;
   assign key = key_q != 4'h0;
   assign rst_pin = rst_q != 4'h0;
endmodule
`default_nettype wire

// File: verification/tb_drive_setup_policy_decoder.sv
// self-checking bench for the drive setup decoder
`timescale 1ns/1ps
`default_nettype none
module tb_drive_setup_policy_decoder;
   import dsp_pkg::*;
   logic sys_clk, reset_n, ce, wr, rd, char2, pres, key, rpin, trip, pmode, fmode, r485;
   logic attach, key_cmd, rst_cmd, ct, tune, entry, delta, spwm, racc, alarm, shut, dec, ind, irq;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, d, seed;
   logic [3:0] car;
   logic [7:0] acode;
   logic [6:0] cur, c;
   logic [6:0] mc [18] = '{7'h00, 7'h01, 7'h03, 7'h05, 7'h06, 7'h0d, 7'h0f, 7'h10, 7'h17,
      7'h64, 7'h65, 7'h67, 7'h69, 7'h6a, 7'h71, 7'h73, 7'h74, 7'h7b};
   logic [4:0] pc [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0e, 5'h0f, 5'h10, 5'h11};
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_acc = 0;
   dsp_drive_setup_policy #(.LOSS_CYC(20)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .clk_en(ce), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .second_characteristic_select(char2), .operator_panel_present(pres),
      .panel_stop_key(key), .reset_input(rpin), .protective_trip(trip),
      .panel_operation_mode(pmode), .fieldbus_operation_mode(fmode), .rs485_link_mode(r485),
      .therm_const_torque(ct), .autotune_select(tune), .motor_const_entry(entry),
      .delta_connection(delta), .carrier_code(car), .soft_pwm_active(spwm),
      .reset_accept(racc), .panel_loss_alarm(alarm), .alarm_code(acode), .drive_shutoff(shut),
      .decel_stop_req(dec), .panel_stop_indication(ind), .irq(irq));
   dsp_panel_model i_panel (.sys_clk(sys_clk), .attach(attach), .key_cmd(key_cmd),
      .rst_cmd(rst_cmd), .present(pres), .key(key), .rst_pin(rpin));
   // ========================================
   // helpers
   function automatic logic [6:0] mbase(input logic [6:0] x);
      mbase = (x >= 7'h64) ? x - 7'h64 : x;
   endfunction
   function automatic logic mvalid(input logic [6:0] x);
      mvalid = mbase(x) inside {7'h00, 7'h01, 7'h03, 7'h05, 7'h06, 7'h0d, 7'h0f, 7'h10, 7'h17};
   endfunction
   function automatic logic exp_ct(input logic [6:0] x, input logic s);
      exp_ct = (x >= 7'h64 && s) || mbase(x) inside {7'h01, 7'h0d, 7'h0f, 7'h10};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bw(input logic [4:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic br(input logic [4:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic pulse(input logic r);
      @(posedge sys_clk);
      if (r) rst_cmd <= 1'b1;
      else key_cmd <= 1'b1;
      @(posedge sys_clk);
      rst_cmd <= 1'b0;
      key_cmd <= 1'b0;
      hold(14);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end
   // accepted reset requests, one-cycle pulses
   always @(posedge sys_clk) begin
      if (racc === 1'b1) n_acc++;
   end
   // ========================================
   // main sequence
   initial begin
      seed = 32'h8db2;
      {reset_n, wr, rd, char2, trip, pmode, fmode, r485, attach, key_cmd, rst_cmd} = '0;
      ce = 1'b1;
      addr = 5'h00;
      wdata = 32'h0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      br(OFS_MOTOR, d); chk("motor", 32'h0, d);
      br(OFS_CARRIER, d); chk("carrier", 32'h1, d);
      br(OFS_SOFTPWM, d); chk("soft", 32'h1, d);
      br(OFS_POLICY, d); chk("policy", 32'he, d);
      br(5'h02, d); chk("unmapped", 32'h0, d);
      bw(OFS_POLICY, 32'h2);
      hold(40); chk("alarm", 32'h0, alarm);
      $display("reset and power-up test done");
      bw(OFS_IRQ_EN, 32'h4);
      for (int i = 0; i < 36; i++) begin
         bw(OFS_MOTOR, {25'h0, mc[i % 18]});
         char2 <= i >= 18;
         hold(8);
         chk("ct", exp_ct(mc[i % 18], i >= 18), ct);
         chk("tune", mbase(mc[i % 18]) inside {7'h03, 7'h0d, 7'h17}, tune);
         chk("entry", mbase(mc[i % 18]) inside {7'h05, 7'h06, 7'h0f, 7'h10}, entry);
         chk("delta", mbase(mc[i % 18]) inside {7'h06, 7'h10}, delta);
      end
      cur = 7'h7b;
      for (int i = 0; i < 17; i++) begin
         c = (i == 16) ? 7'h7f : 7'($random(seed));
         bw(OFS_MOTOR, {25'h0, c});
         if (mvalid(c)) cur = c;
         br(OFS_MOTOR, d); chk("motor", {25'h0, cur}, d);
      end
      hold(2); chk("irq", 32'h1, irq);
      br(OFS_IRQ_STS, d); chk("irq_sts", 32'h4, d & 32'h4);
      bw(OFS_IRQ_CLR, 32'hf);
      hold(3); chk("irq", 32'h0, irq);
      $display("motor code test done");
      for (int k = 0; k < 16; k++) begin
         bw(OFS_CARRIER, k);
         hold(2); chk("car", k, car);
         chk("spwm", k <= 5, spwm);
      end
      bw(OFS_CARRIER, 32'h10);
      bw(OFS_SOFTPWM, 32'h2);
      bw(OFS_POLICY, 32'h4);
      br(OFS_CARRIER, d); chk("carrier", 32'hf, d);
      br(OFS_POLICY, d); chk("policy", 32'h2, d);
      bw(OFS_CARRIER, 32'h3);
      hold(2); chk("spwm", 32'h1, spwm);
      bw(OFS_SOFTPWM, 32'h0);
      hold(2); chk("spwm", 32'h0, spwm);
      // write with the clock enable low must not land
      ce <= 1'b0;
      bw(OFS_CARRIER, 32'h7);
      ce <= 1'b1;
      br(OFS_CARRIER, d);
      chk("freeze", 32'h3, d);
      for (int k = 0; k < 8; k++) begin
         bw(OFS_POLICY, pc[k]);
         br(OFS_STATUS, d); chk("det", pc[k] inside {2, 3, 16, 17}, d[5]);
      end
      $display("pwm and policy code test done");
      bw(OFS_POLICY, 32'h2);
      attach <= 1'b1; hold(10);
      attach <= 1'b0; hold(15);
      attach <= 1'b1; hold(8);
      attach <= 1'b0; hold(15);
      chk("alarm", 32'h0, alarm);
      hold(25); chk("alarm", 32'h1, alarm);
      chk("acode", {24'h0, PANEL_LOSS_CODE}, acode);
      chk("shut", 32'h1, shut);
      attach <= 1'b1; hold(6);
      pulse(1'b1); chk("alarm", 32'h0, alarm);
      r485 <= 1'b1; attach <= 1'b0;
      hold(40); chk("alarm", 32'h0, alarm);
      r485 <= 1'b0; attach <= 1'b1;
      bw(OFS_POLICY, 32'h0);
      hold(8); attach <= 1'b0;
      hold(40); chk("alarm", 32'h0, alarm);
      attach <= 1'b1;
      $display("panel loss test done");
      fmode <= 1'b1;
      pulse(1'b0); chk("dec", 32'h0, dec);
      pmode <= 1'b1;
      pulse(1'b0); chk("dec", 32'h1, dec);
      chk("ind", 32'h1, ind);
      chk("alarm", 32'h0, alarm);
      pulse(1'b1); chk("dec", 32'h0, dec);
      bw(OFS_POLICY, 32'h1);
      pulse(1'b0);
      pulse(1'b1); chk("dec", 32'h1, dec);
      trip <= 1'b1;
      pulse(1'b1); chk("dec", 32'h0, dec);
      trip <= 1'b0; pmode <= 1'b0;
      bw(OFS_POLICY, 32'he);
      pulse(1'b0); chk("dec", 32'h1, dec);
      chk("racc", 32'h3, n_acc);
      br(OFS_IRQ_STS, d);
      chk("irq_sts", 32'hf, d);
      $display("stop key and reset test done");
      test_done();
   end
endmodule
`default_nettype wire
